// [hw/tos_pkg.sv]
// Shared constants for the one-shot and monostable timer block.
package tos_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] TOS_CTRL_OFS = 8'h00;
    localparam logic [7:0] TOS_PERIOD_OFS = 8'h04;
    localparam logic [7:0] TOS_COUNT_OFS = 8'h08;
    localparam logic [7:0] TOS_STATUS_OFS = 8'h0c;

    // Field positions inside the control register.
    localparam int TOS_CTRL_RUN_BIT = 0;
    localparam int TOS_CTRL_MODE_LSB = 8;
    localparam int TOS_CTRL_MODE_MSB = 12;

    // Field positions inside the status register.
    localparam int TOS_STAT_COUNTING_BIT = 0;
    localparam int TOS_STAT_LEVEL_BIT = 1;

    // Reset values.
    localparam logic [7:0] TOS_PERIOD_RST = 8'hff;
    localparam logic [4:0] TOS_MODE_RST = 5'h08;

    // Upper mode groups.
    localparam logic [1:0] TOS_GRP_ONESHOT = 2'h1;
    localparam logic [1:0] TOS_GRP_MONO = 2'h2;

    // Lower mode codes.
    localparam logic [2:0] TOS_LO_SOFT = 3'h0;
    localparam logic [2:0] TOS_LO_RISE = 3'h1;
    localparam logic [2:0] TOS_LO_FALL = 3'h2;
    localparam logic [2:0] TOS_LO_ANY = 3'h3;
    localparam logic [2:0] TOS_LO_RISE_RISE = 3'h4;
    localparam logic [2:0] TOS_LO_FALL_FALL = 3'h5;
    localparam logic [2:0] TOS_LO_RISE_LOW = 3'h6;
    localparam logic [2:0] TOS_LO_FALL_HIGH = 3'h7;

    // AXI response codes.
    localparam logic [1:0] TOS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TOS_RESP_SLVERR = 2'h2;

    // Timer sequencing states.
    typedef enum logic [0:0] {
        TOS_ST_WAIT = 1'b0,
        TOS_ST_COUNT = 1'b1
    } tos_state_t;

endpackage : tos_pkg

// [hw/tos_edge_sync.sv]
// Pin synchroniser with debounced level and registered edge pulses.
`timescale 1ns/10ps
module tos_edge_sync
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Asynchronous pin.
    input wire logic pin_in,
    // Qualified level and one-cycle edge pulses.
    output logic level,
    output logic rise,
    output logic fall
);

    logic s1_q; // First stage, read only by the second stage.
    logic s2_q; // Second stage.
    logic s3_q; // Third stage, compared with the second.
    logic level_q; // Accepted level.
    logic rise_q; // Rising edge pulse.
    logic fall_q; // Falling edge pulse.

    ////////////////////////////////////////////////////////////////////////
    // Three flops keep metastability away from the logic.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the second and third stages agree.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else if ((s2_q == s3_q) && (s2_q != level_q))
        begin
            level_q <= s2_q;
            rise_q <= s2_q;
            fall_q <= !s2_q;
        end
        else
        begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
    end

    assign level = level_q;
    assign rise = rise_q;
    assign fall = fall_q;

endmodule : tos_edge_sync

// [hw/tos_timer.sv]
// One-shot, monostable and level one-shot timer with an AXI4-Lite slave.
//
// Overview of operation
// RQ1: Edge one-shot starts on chosen edge while running.
// RQ2: Mode 100: rising start, rising edge resets.
// RQ3: Mode 101: falling start, falling edge resets.
// RQ4: Mode 110: rising start, low level resets.
// RQ5: Mode 111: falling start, high level resets.
// RQ6: Monostable starts on chosen edge while running.
// RQ7: Level mode 110: high starts, low holds reset.
// RQ8: Level mode 111: low starts, high holds reset.
// RQ9: One-shot match clears run, count stops zero.
// RQ10: Monostable match stops count, run stays set.
// RQ11: After run toggles, new edge needed to restart.
// RQ12: Software avoids reserved mode codes.
// RQ13: Clearing run stops the timer at once.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module tos_timer
    import tos_pkg::*;
#(
    parameter int CW = 8 // Counter and period width.
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // External reset signal from an on-chip source, asynchronous.
    input wire logic external_reset_signal,
    // Timer state.
    output logic [CW-1:0] count_value,
    output logic run,
    // AXI4-Lite write address channel.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic ers_level; // Qualified level of the external reset signal.
    logic ers_rise; // Qualified rising edge.
    logic ers_fall; // Qualified falling edge.
    logic run_q; // Run bit.
    logic [4:0] mode_q; // Five-bit mode code.
    logic [CW-1:0] period_q; // Period value.
    logic [CW-1:0] count_q; // Count value.
    tos_state_t state_q; // Waiting for a start or counting.
    logic aw_have_q; // Write address held.
    logic w_have_q; // Write data held.
    logic [7:0] awaddr_q; // Held write address.
    logic [31:0] wdata_q; // Held write data.
    logic [3:0] wstrb_q; // Held byte enables.
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write; // Both halves of a write are here.
    logic ctrl_wr; // Write to the control register, whatever the byte lanes.
    logic start_evt; // Start condition for edge or software modes.
    logic edge_rst; // Edge that resets a running count.
    logic lvl_rst; // Level that resets a running count.
    logic lvl_mode; // Level-triggered one-shot mode.
    logic lvl_gate; // Level that lets the level mode count.
    logic oneshot; // Match clears the run bit.
    logic valid_mode; // Mode code belongs to this group.
    logic match; // Count equals period while counting.
    logic hw_stop; // Hardware clears the run bit this cycle.

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser.
    tos_edge_sync u_sync
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in(external_reset_signal),
        .level(ers_level),
        .rise(ers_rise),
        .fall(ers_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode decode.
    always_comb
    begin
        start_evt = 1'b0;
        edge_rst = 1'b0;
        lvl_rst = 1'b0;
        lvl_mode = 1'b0;
        lvl_gate = 1'b0;
        oneshot = 1'b0;
        valid_mode = 1'b0;
        if (mode_q[4:3] == TOS_GRP_ONESHOT)
        begin
            valid_mode = 1'b1;
            oneshot = 1'b1;
            case (mode_q[2:0])
                TOS_LO_SOFT: start_evt = 1'b1;
                TOS_LO_RISE: start_evt = ers_rise; // RQ1
                TOS_LO_FALL: start_evt = ers_fall; // RQ1
                TOS_LO_ANY: start_evt = ers_rise | ers_fall; // RQ1
                TOS_LO_RISE_RISE:
                begin
                    start_evt = ers_rise; // RQ2
                    edge_rst = ers_rise; // RQ2
                end
                TOS_LO_FALL_FALL:
                begin
                    start_evt = ers_fall; // RQ3
                    edge_rst = ers_fall; // RQ3
                end
                TOS_LO_RISE_LOW:
                begin
                    start_evt = ers_rise; // RQ4
                    lvl_rst = !ers_level; // RQ4
                end
                default:
                begin
                    start_evt = ers_fall; // RQ5
                    lvl_rst = ers_level; // RQ5
                end
            endcase
        end
        else if (mode_q[4:3] == TOS_GRP_MONO)
        begin
            case (mode_q[2:0])
                TOS_LO_RISE:
                begin
                    valid_mode = 1'b1;
                    start_evt = ers_rise; // RQ6
                end
                TOS_LO_FALL:
                begin
                    valid_mode = 1'b1;
                    start_evt = ers_fall; // RQ6
                end
                TOS_LO_ANY:
                begin
                    valid_mode = 1'b1;
                    start_evt = ers_rise | ers_fall; // RQ6
                end
                TOS_LO_RISE_LOW:
                begin
                    valid_mode = 1'b1;
                    oneshot = 1'b1;
                    lvl_mode = 1'b1;
                    lvl_gate = ers_level; // RQ7
                end
                TOS_LO_FALL_HIGH:
                begin
                    valid_mode = 1'b1;
                    oneshot = 1'b1;
                    lvl_mode = 1'b1;
                    lvl_gate = !ers_level; // RQ8
                end
                // Reserved codes leave the timer idle.
                default: valid_mode = 1'b0; // RQ12
            endcase
        end
    end

    // A match counts only while a level mode's gate is open.
    assign match = run_q && (state_q == TOS_ST_COUNT) && (count_q == period_q)
        && !(lvl_mode && !lvl_gate);
    assign hw_stop = match && oneshot; // RQ9

    ////////////////////////////////////////////////////////////////////////
    // Timer sequencing and count. Clearing run parks the count where it is.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_q <= TOS_ST_WAIT;
            count_q <= '0;
        end
        else if (!run_q || !valid_mode)
        begin
            // Leaving run drops to WAIT, so an edge mode restarts only on a fresh edge.
            state_q <= TOS_ST_WAIT; // RQ13 RQ11
        end
        else
        begin
            case (state_q)
                TOS_ST_WAIT:
                begin
                    if (lvl_mode)
                    begin
                        if (lvl_gate)
                        begin
                            state_q <= TOS_ST_COUNT; // RQ7 RQ8
                        end
                        else
                        begin
                            count_q <= '0; // RQ7 RQ8
                        end
                    end
                    else if (start_evt)
                    begin
                        state_q <= TOS_ST_COUNT; // RQ1 RQ6
                    end
                end
                TOS_ST_COUNT:
                begin
                    if (lvl_mode && !lvl_gate)
                    begin
                        state_q <= TOS_ST_WAIT; // RQ7 RQ8
                        count_q <= '0;
                    end
                    else if (match)
                    begin
                        // Monostable keeps run set and waits for an edge.
                        state_q <= TOS_ST_WAIT; // RQ9 RQ10
                        count_q <= '0; // RQ9 RQ10
                    end
                    else if (edge_rst || lvl_rst)
                    begin
                        count_q <= '0; // RQ2 RQ3 RQ4 RQ5
                    end
                    else
                    begin
                        count_q <= count_q + 1'b1;
                    end
                end
                default: state_q <= TOS_ST_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and period registers; software beats a same-cycle hardware stop.
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign ctrl_wr = do_write && (awaddr_q == TOS_CTRL_OFS);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            run_q <= 1'b0;
        end
        else if (ctrl_wr && wstrb_q[0])
        begin
            run_q <= wdata_q[TOS_CTRL_RUN_BIT];
        end
        else if (hw_stop)
        begin
            run_q <= 1'b0; // RQ9
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            mode_q <= TOS_MODE_RST;
            period_q <= CW'(TOS_PERIOD_RST);
        end
        else if (do_write)
        begin
            if ((awaddr_q == TOS_CTRL_OFS) && wstrb_q[1])
            begin
                mode_q <= wdata_q[TOS_CTRL_MODE_MSB:TOS_CTRL_MODE_LSB];
            end
            if ((awaddr_q == TOS_PERIOD_OFS) && wstrb_q[0])
            begin
                period_q <= wdata_q[CW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channels: address and data are taken in either order.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= TOS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                // Count and status are read-only; unmapped gets an error.
                if ((awaddr_q == TOS_CTRL_OFS) || (awaddr_q == TOS_PERIOD_OFS))
                begin
                    bresp_q <= TOS_RESP_OKAY;
                end
                else
                begin
                    bresp_q <= TOS_RESP_SLVERR;
                end
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one read in flight, data one cycle after the address.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= TOS_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= TOS_RESP_OKAY;
            rdata_q <= '0;
            case (s_axi_araddr)
                TOS_CTRL_OFS:
                begin
                    rdata_q[TOS_CTRL_RUN_BIT] <= run_q;
                    rdata_q[TOS_CTRL_MODE_MSB:TOS_CTRL_MODE_LSB] <= mode_q;
                end
                TOS_PERIOD_OFS: rdata_q[CW-1:0] <= period_q;
                TOS_COUNT_OFS: rdata_q[CW-1:0] <= count_q;
                TOS_STATUS_OFS:
                begin
                    rdata_q[TOS_STAT_COUNTING_BIT] <= (state_q == TOS_ST_COUNT) && run_q;
                    rdata_q[TOS_STAT_LEVEL_BIT] <= ers_level;
                end
                default: rresp_q <= TOS_RESP_SLVERR;
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drive, all from flops.
    assign count_value = count_q;
    assign run = run_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : tos_timer

// [bench/tos_timer_assertions.sv]
// Port-level checker for the one-shot and monostable timer.
`timescale 1ns/10ps
module tos_timer_assertions
    import tos_pkg::*;
#(
    parameter int CW = 8 // Counter width of the watched timer.
)
(
    // Clock, reset and gate pin.
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic external_reset_signal,
    // Timer state.
    input wire logic [CW-1:0] count_value,
    input wire logic run,
    // Register bus signals.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////////
    // Mode and period shadows, snooped at a whole write.
    logic [4:0] mode_q; // Snooped mode code.
    logic [CW-1:0] per_q; // Snooped period value.
    logic wr_go; // Address and data taken together.
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // The shadow leads the register by one cycle; the checks do not skip the cycle after a write.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            mode_q <= TOS_MODE_RST;
        else if (wr_go && s_axi_awaddr == TOS_CTRL_OFS && s_axi_wstrb[1])
            mode_q <= s_axi_wdata[12:8];
    end
    // Period shadow.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            per_q <= CW'(TOS_PERIOD_RST);
        else if (wr_go && s_axi_awaddr == TOS_PERIOD_OFS && s_axi_wstrb[0])
            per_q <= s_axi_wdata[CW-1:0];
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_step;
        $changed(count_value) |-> count_value == $past(count_value) + 1'b1 || count_value == 0;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_stop;
        (!run && $stable(external_reset_signal))[*6] |-> $stable(count_value);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_lvlo;
        (run && (mode_q == 5'h0e || mode_q == 5'h16) && !external_reset_signal)[*8]
            |-> count_value == 0;
    endproperty
    a_lvlo: assert property (p_lvlo) else $error("low level did not hold reset");
    property p_lvhi;
        (run && (mode_q == 5'h0f || mode_q == 5'h17) && external_reset_signal)[*8]
            |-> count_value == 0;
    endproperty
    a_lvhi: assert property (p_lvhi) else $error("high level did not hold reset");
    property p_oneshot;
        run && mode_q[4:3] == TOS_GRP_ONESHOT && count_value == per_q
            && count_value == $past(count_value) + 1'b1 |=> !run && count_value == 0;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot end wrong");
    property p_mono;
        run && mode_q inside {5'h11, 5'h12, 5'h13} && count_value == per_q
            && count_value == $past(count_value) + 1'b1 |=> run && count_value == 0;
    endproperty
    a_mono: assert property (p_mono) else $error("monostable end wrong");
endmodule : tos_timer_assertions

bind tos_timer tos_timer_assertions #(.CW(CW)) u_tos_timer_assertions (.*);

// [bench/tos_src_model.sv]
// On-chip source that drives the timer's external gate signal.
`timescale 1ns/10ps
module tos_src_model
(
    // Clock.
    input wire logic ref_clk,
    // Driven gate level.
    output logic external_reset_signal
);
    // Idles low.
    initial external_reset_signal = 1'b0;
    // New level just after an edge, then held for w cycles.
    task automatic drive(input logic v, input int w);
        @(posedge ref_clk);
        external_reset_signal <= v;
        repeat (w) @(posedge ref_clk);
    endtask : drive
endmodule : tos_src_model

// [bench/tos_timer_tb.sv]
// Self-checking testbench of the one-shot and monostable timer.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tos_timer_tb
    import tos_pkg::*;
;
    logic ref_clk, rstn, run; // Clock, reset and run bit.
    logic ers; // Gate signal from the source model.
    logic [7:0] count_value, awaddr, araddr; // Count and bus addresses.
    logic awvalid, awready, wvalid, wready, bvalid, bready, arready, arvalid, rvalid, rready;
    logic [31:0] wdata, rdata; // Bus data.
    logic [3:0] wstrb; // Byte strobes.
    logic [1:0] bresp, rresp; // Bus responses.
    int error_cnt = 0, tests_run = 0, cyc = 0; // Counters.
    tos_src_model u_tos_src_model (.ref_clk(ref_clk), .external_reset_signal(ers));
    tos_timer #(.CW(8)) u_tos_timer (.ref_clk(ref_clk), .rstn(rstn),
        .external_reset_signal(ers), .count_value(count_value), .run(run),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a watchdog that cuts a hang short.
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    // Reset for five cycles, also used mid-run.
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask : do_reset
    // One write; both channels offered together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        `CHK(bresp, er)
    endtask : wr
    // One read; data and response taken at the handshake edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        `CHK(rresp, er)
    endtask : rd
    // Mode and run in one control write.
    task automatic ctl(input logic [4:0] m, input logic r);
        wr(TOS_CTRL_OFS, {19'h0, m, 7'h0, r}, 4'h3, TOS_RESP_OKAY);
    endtask : ctl
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, read-only and unmapped places, byte strobes.
    task automatic t_regs();
        logic [31:0] d;
        `CHK({run, count_value}, 9'h000)
        rd(TOS_CTRL_OFS, d, TOS_RESP_OKAY);
        `CHK(d, {19'h0, TOS_MODE_RST, 8'h00})
        rd(TOS_PERIOD_OFS, d, TOS_RESP_OKAY);
        `CHK(d, {24'h0, TOS_PERIOD_RST})
        rd(8'h10, d, TOS_RESP_SLVERR);
        `CHK(d, 32'h0)
        wr(TOS_COUNT_OFS, 32'h5, 4'hf, TOS_RESP_SLVERR);
        wr(TOS_CTRL_OFS, 32'h1f00, 4'h1, TOS_RESP_OKAY);
        rd(TOS_CTRL_OFS, d, TOS_RESP_OKAY);
        `CHK(d, {19'h0, TOS_MODE_RST, 8'h00})
    endtask : t_regs
    // Edge starts in both groups: wrong edge ignored, one-shot clears run.
    task automatic t_start();
        logic pre, nx;
        for (int g = 1; g <= 2; g++)
            for (int lo = 1; lo <= 3; lo++)
            begin
                pre = (lo != 2);
                nx = (lo == 3) ? !pre : pre;
                wr(TOS_PERIOD_OFS, 32'h0f, 4'h1, TOS_RESP_OKAY);
                u_tos_src_model.drive(pre, 8);
                ctl({g[1:0], lo[2:0]}, 1'b1);
                if (lo != 3)
                begin
                    u_tos_src_model.drive(!pre, 10);
                    `CHK(count_value, 8'h00)
                end
                u_tos_src_model.drive(nx, 10);
                `CHK(count_value != 8'h00, 1'b1)
                repeat (20) @(posedge ref_clk);
                `CHK(count_value, 8'h00)
                `CHK(run, (g == 2))
                ctl({g[1:0], lo[2:0]}, 1'b0);
            end
    endtask : t_start
    // Stop holds the count; run set again waits for a fresh edge.
    task automatic t_hold();
        logic [7:0] c;
        do_reset();
        u_tos_src_model.drive(1'b0, 8);
        ctl(5'h09, 1'b1);
        u_tos_src_model.drive(1'b1, 20);
        ctl(5'h09, 1'b0);
        repeat (2) @(posedge ref_clk);
        c = count_value;
        repeat (10) @(posedge ref_clk);
        `CHK(count_value, c)
        ctl(5'h09, 1'b1);
        repeat (10) @(posedge ref_clk);
        `CHK(count_value, c)
        u_tos_src_model.drive(1'b0, 8);
        u_tos_src_model.drive(1'b1, 10);
        `CHK(count_value > c, 1'b1)
        ctl(5'h09, 1'b0);
    endtask : t_hold
    // Hardware reset by edge or level; reserved codes are never programmed.
    task automatic t_levels();
        logic [4:0] tbl [6] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h16, 5'h17};
        logic [4:0] m;
        for (int i = 0; i < 6; i++)
        begin
            m = tbl[i];
            do_reset();
            u_tos_src_model.drive(m[0], 8);
            ctl(m, 1'b1);
            repeat (10) @(posedge ref_clk);
            `CHK(count_value, 8'h00)
            u_tos_src_model.drive(!m[0], 20);
            `CHK(count_value >= 8'h08, 1'b1)
            u_tos_src_model.drive(m[0], 12);
            if (m[1])
                `CHK(count_value, 8'h00)
            else
            begin
                `CHK(count_value >= 8'h14, 1'b1)
                u_tos_src_model.drive(!m[0], 8);
                `CHK(count_value < 8'h0c, 1'b1)
            end
            ctl(m, 1'b0);
        end
    endtask : t_levels
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        {awvalid, wvalid, arvalid, bready, rready} = 5'h03;
        {awaddr, araddr, wdata, wstrb} = '0;
        do_reset();
        t_regs();
        t_start();
        t_hold();
        t_levels();
        wrap_up();
    end
endmodule : tos_timer_tb
